/* nfa_pkg.sv */
package nfa_pkg;

    // Clock and strobe timing, figures in ns
    localparam int CLK_NS = 10;
    localparam int T_WP_NS = 25;
    localparam int T_WH_NS = 15;
    localparam int T_ADL_NS = 70;
    localparam int T_WB_NS = 100;
    localparam int T_RP_NS = 40;
    localparam int T_REH_NS = 15;

    // Least times, rounded up to whole cycles
    localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WH_CYC = 8'((T_WH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ADL_CYC = 8'((T_ADL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WB_CYC = 8'((T_WB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] REH_CYC = 8'((T_REH_NS + CLK_NS - 1) / CLK_NS);

    // Command codes
    localparam logic [7:0] CMD_SET = 8'hEF;
    localparam logic [7:0] CMD_GET = 8'hEE;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ = 8'h00;

    // Feature addresses and first-byte field masks
    localparam logic [7:0] FA_TIMING = 8'h01;
    localparam logic [7:0] FA_DRIVE = 8'h80;
    localparam logic [7:0] FA_RBPD = 8'h81;
    localparam logic [7:0] FA_ARRAY = 8'h90;
    localparam logic [7:0] MASK_TIMING = 8'h07;
    localparam logic [7:0] MASK_STRENGTH = 8'h03;
    localparam logic [7:0] MASK_ARRAY = 8'h0B;
    localparam int SR_RDY_BIT = 6;

    // Register offsets of the software port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_FADDR = 4'h1;
    localparam logic [3:0] REG_PARAM0 = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h6;

    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_GET = 1;
    localparam int CTRL_POLL = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_RELAXED = 3;
    localparam int ST_SR_LSB = 8;

    // Pin group driven toward the target
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic io_oe;
        logic [7:0] io_o;
    } nfa_pins_t;

    localparam nfa_pins_t PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
        we_n: 1'b1, re_n: 1'b1, io_oe: 1'b0, io_o: 8'h00};

    typedef enum logic [3:0] {
        S_IDLE, S_RDY, S_CMD, S_ADR, S_ADL, S_DIN, S_WB, S_BUSY,
        S_STCMD, S_STRD, S_RMCMD, S_DOUT, S_DONE
    } nfa_state_t;

endpackage

/* nfa_timer.sv */
module nfa_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Load and expiry
    input wire logic load,
    input wire logic [7:0] count,
    output logic done
);

    logic [7:0] cnt_q;

    // Down counter; a load cycle never reads as expired
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign done = (cnt_q == 8'h00) && !load;

endmodule // nfa_timer

/* nfa_host.sv */
// Functional notes
// RQ1 - Set-features stores four bytes at address
// RQ2 - Feature commands only while all dies idle
// RQ3 - Set-features byte enters set mode
// RQ4 - Host sends address, waits before data
// RQ5 - One byte latched per write rising edge
// RQ6 - Busy after fourth byte; status shows completion
// RQ7 - Interface change on timing uses longer busy
// RQ8 - Get-features returns four bytes of address
// RQ9 - Get-features byte enters get mode
// RQ10 - Busy after get address while fetching
// RQ11 - After status polling, issue read mode
// RQ12 - Read four bytes only after busy ends
// RQ13 - Array mode: normal, OTP, protect, ECC
// RQ14 - Array mode clears at power cycle
// RQ15 - Timing mode 0..4, default zero
// RQ16 - Host picks only advertised timing modes
// RQ17 - Drive strength four steps, full default
// RQ18 - Reduced drive may need relaxed timing
// RQ19 - Four feature addresses, others reserved
// RQ20 - Settings volatile, survive reset command
// RQ21 - Host writes zeros in reserved bits, bytes; byte 0 to an unknown address passes unmasked
// RQ22 - Readback gives last written, reserved zero
module nfa_host #(
    parameter logic [7:0] SUPP_MODES = 8'h0F
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Software register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Target control pins
    output logic CE_N,
    output logic CLE,
    output logic ALE,
    output logic WE_N,
    output logic RE_N,
    // Target data bus and ready line
    output logic [7:0] IO_O,
    output logic IO_OE,
    input wire logic [7:0] IO_I,
    input wire logic RB_N
);

    nfa_pkg::nfa_state_t state_q;
    nfa_pkg::nfa_pins_t pins_q;
    logic ph_q, tld_q, tdone, go_q, get_q, poll_q;
    logic done_q, refused_q, relaxed_q, rb_s1, rb_s;
    logic [1:0] idx_q;
    logic [7:0] tval_q, sr_q, faddr_q, io_s1, io_s, lo_cyc;
    logic [7:0] wparam_q [4];
    logic [7:0] rparam_q [4];
    logic start_wr, mode_ok;

    // Reserved bits and bytes are zero; unknown addresses pass byte 0 whole
    function automatic logic [7:0] byte_mask(logic [7:0] fa, logic [1:0] i);
        if (i != 2'h0) return 8'h00;
        if (fa == nfa_pkg::FA_TIMING) return nfa_pkg::MASK_TIMING;
        if (fa == nfa_pkg::FA_DRIVE || fa == nfa_pkg::FA_RBPD)
            return nfa_pkg::MASK_STRENGTH;
        if (fa == nfa_pkg::FA_ARRAY) return nfa_pkg::MASK_ARRAY;
        return 8'hFF;
    endfunction

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    nfa_timer u_timer (
        .clk(CLK),
        .rst_n(RESET_N),
        .load(tld_q),
        .count(tval_q),
        .done(tdone)
    );

    // Pin inputs cross into CLK through two flops
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rb_s1 <= 1'b0;
            rb_s <= 1'b0;
            io_s1 <= 8'h00;
            io_s <= 8'h00;
        end else begin
            rb_s1 <= RB_N;
            rb_s <= rb_s1;
            io_s1 <= IO_I;
            io_s <= io_s1;
        end
    end

    // Weaker drive slows edges, so write strobes are held twice as long
    assign lo_cyc = relaxed_q ? 8'(2 * nfa_pkg::WP_CYC) : nfa_pkg::WP_CYC;
    assign start_wr = WR && ADDR == nfa_pkg::REG_CTRL && WDATA[nfa_pkg::CTRL_START];
    assign mode_ok = WDATA[nfa_pkg::CTRL_GET] || faddr_q != nfa_pkg::FA_TIMING
        || SUPP_MODES[wparam_q[0][2:0]];

    // Command acceptance and sticky status
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            go_q <= 1'b0;
            get_q <= 1'b0;
            poll_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (state_q == nfa_pkg::S_DONE) done_q <= 1'b1;
            if (start_wr) begin
                if (state_q == nfa_pkg::S_IDLE && !go_q && mode_ok) begin // RQ16
                    go_q <= 1'b1;
                    get_q <= WDATA[nfa_pkg::CTRL_GET];
                    poll_q <= WDATA[nfa_pkg::CTRL_POLL];
                    done_q <= 1'b0;
                    refused_q <= 1'b0;
                end else begin
                    refused_q <= 1'b1;
                end
            end
        end
    end

    // Relaxed strobes follow the last drive strength we set
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            relaxed_q <= 1'b0;
        end else if (state_q == nfa_pkg::S_DONE && !get_q
                && faddr_q == nfa_pkg::FA_DRIVE) begin
            relaxed_q <= wparam_q[0][1:0] != 2'h0; // RQ18
        end
    end

    // Register writes, frozen while a sequence runs
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            faddr_q <= 8'h00;
            wparam_q <= '{default: 8'h00};
        end else if (WR && state_q == nfa_pkg::S_IDLE && !go_q) begin
            if (ADDR == nfa_pkg::REG_FADDR) faddr_q <= WDATA[7:0];
            for (int i = 0; i < 4; i++) begin
                if (ADDR == nfa_pkg::REG_PARAM0 + 4'(i))
                    wparam_q[i] <= WDATA[7:0];
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            RDATA <= 32'h00000000;
        end else if (RD) begin
            RDATA <= 32'h00000000;
            if (ADDR == nfa_pkg::REG_CTRL)
                RDATA <= {29'h0, poll_q, get_q, 1'b0};
            if (ADDR == nfa_pkg::REG_FADDR) RDATA <= {24'h0, faddr_q};
            for (int i = 0; i < 4; i++) begin
                if (ADDR == nfa_pkg::REG_PARAM0 + 4'(i))
                    RDATA <= {16'h0, wparam_q[i], rparam_q[i]};
            end
            if (ADDR == nfa_pkg::REG_STATUS)
                RDATA <= {16'h0, sr_q, 4'h0, relaxed_q, refused_q, done_q,
                    state_q != nfa_pkg::S_IDLE};
        end else begin
            RDATA <= 32'h00000000;
        end
    end

    // Sequencer: drives the pins and steps through each phase
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_q <= nfa_pkg::S_IDLE;
            pins_q <= nfa_pkg::PINS_IDLE;
            ph_q <= 1'b0;
            idx_q <= 2'h0;
            tld_q <= 1'b0;
            tval_q <= 8'h00;
            sr_q <= 8'h00;
            rparam_q <= '{default: 8'h00};
        end else begin
            tld_q <= 1'b0;
            unique case (state_q)
                nfa_pkg::S_IDLE: if (go_q) begin
                    pins_q.ce_n <= 1'b0;
                    state_q <= nfa_pkg::S_RDY;
                end
                nfa_pkg::S_RDY: if (rb_s) begin // RQ2
                    pins_q.cle <= 1'b1;
                    pins_q.io_oe <= 1'b1;
                    pins_q.io_o <= get_q ? nfa_pkg::CMD_GET : nfa_pkg::CMD_SET;
                    pins_q.we_n <= 1'b0;
                    tld_q <= 1'b1;
                    tval_q <= lo_cyc;
                    state_q <= nfa_pkg::S_CMD;
                end
                nfa_pkg::S_CMD, nfa_pkg::S_ADR, nfa_pkg::S_DIN,
                nfa_pkg::S_STCMD, nfa_pkg::S_RMCMD: if (tdone) begin
                    tld_q <= 1'b1;
                    if (!ph_q) begin
                        pins_q.we_n <= 1'b1; // target latches here
                        tval_q <= nfa_pkg::WH_CYC;
                        ph_q <= 1'b1;
                    end else begin
                        ph_q <= 1'b0;
                        pins_q.cle <= 1'b0;
                        pins_q.ale <= 1'b0;
                        unique case (state_q)
                            nfa_pkg::S_CMD: begin
                                pins_q.ale <= 1'b1;
                                pins_q.io_o <= faddr_q;
                                pins_q.we_n <= 1'b0;
                                tval_q <= lo_cyc;
                                state_q <= nfa_pkg::S_ADR;
                            end
                            nfa_pkg::S_ADR: begin
                                pins_q.io_oe <= !get_q;
                                tval_q <= get_q ? nfa_pkg::WB_CYC
                                    : nfa_pkg::ADL_CYC; // RQ4
                                state_q <= get_q ? nfa_pkg::S_WB
                                    : nfa_pkg::S_ADL;
                            end
                            nfa_pkg::S_DIN: if (idx_q == 2'h3) begin
                                pins_q.io_oe <= 1'b0;
                                tval_q <= nfa_pkg::WB_CYC;
                                state_q <= nfa_pkg::S_WB;
                            end else begin
                                idx_q <= idx_q + 2'h1;
                                pins_q.io_o <= wparam_q[idx_q + 2'h1]
                                    & byte_mask(faddr_q, idx_q + 2'h1); // RQ21
                                pins_q.we_n <= 1'b0;
                                tval_q <= lo_cyc;
                            end
                            nfa_pkg::S_STCMD: begin
                                pins_q.io_oe <= 1'b0;
                                pins_q.re_n <= 1'b0;
                                tval_q <= nfa_pkg::RP_CYC;
                                state_q <= nfa_pkg::S_STRD;
                            end
                            default: begin
                                pins_q.io_oe <= 1'b0;
                                pins_q.re_n <= 1'b0;
                                idx_q <= 2'h0;
                                tval_q <= nfa_pkg::RP_CYC;
                                state_q <= nfa_pkg::S_DOUT;
                            end
                        endcase
                    end
                end
                nfa_pkg::S_ADL: if (tdone) begin
                    idx_q <= 2'h0;
                    pins_q.io_o <= wparam_q[0] & byte_mask(faddr_q, 2'h0);
                    pins_q.we_n <= 1'b0;
                    tld_q <= 1'b1;
                    tval_q <= lo_cyc;
                    state_q <= nfa_pkg::S_DIN;
                end
                nfa_pkg::S_WB: if (tdone) begin
                    if (poll_q) begin
                        pins_q.cle <= 1'b1;
                        pins_q.io_oe <= 1'b1;
                        pins_q.io_o <= nfa_pkg::CMD_STATUS;
                        pins_q.we_n <= 1'b0;
                        tld_q <= 1'b1;
                        tval_q <= lo_cyc;
                        state_q <= nfa_pkg::S_STCMD;
                    end else begin
                        state_q <= nfa_pkg::S_BUSY;
                    end
                end
                nfa_pkg::S_BUSY: if (rb_s) begin // RQ12
                    idx_q <= 2'h0;
                    if (get_q) begin
                        pins_q.re_n <= 1'b0;
                        tld_q <= 1'b1;
                        tval_q <= nfa_pkg::RP_CYC;
                        state_q <= nfa_pkg::S_DOUT;
                    end else begin
                        state_q <= nfa_pkg::S_DONE;
                    end
                end
                nfa_pkg::S_STRD, nfa_pkg::S_DOUT: if (tdone) begin
                    tld_q <= 1'b1;
                    if (!ph_q) begin
                        // Sample late in the low phase, past the sync delay
                        if (state_q == nfa_pkg::S_STRD) sr_q <= io_s;
                        else rparam_q[idx_q] <= io_s & byte_mask(faddr_q, idx_q);
                        pins_q.re_n <= 1'b1;
                        tval_q <= nfa_pkg::REH_CYC;
                        ph_q <= 1'b1;
                    end else begin
                        ph_q <= 1'b0;
                        tval_q <= nfa_pkg::RP_CYC;
                        if (state_q == nfa_pkg::S_STRD && sr_q[nfa_pkg::SR_RDY_BIT]) begin
                            if (get_q) begin // RQ11
                                pins_q.cle <= 1'b1;
                                pins_q.io_oe <= 1'b1;
                                pins_q.io_o <= nfa_pkg::CMD_READ;
                                pins_q.we_n <= 1'b0;
                                tval_q <= lo_cyc;
                                state_q <= nfa_pkg::S_RMCMD;
                            end else begin
                                state_q <= nfa_pkg::S_DONE;
                            end
                        end else if (state_q == nfa_pkg::S_DOUT && idx_q == 2'h3) begin
                            state_q <= nfa_pkg::S_DONE;
                        end else begin
                            if (state_q == nfa_pkg::S_DOUT) idx_q <= idx_q + 2'h1;
                            pins_q.re_n <= 1'b0;
                        end
                    end
                end
                nfa_pkg::S_DONE: begin
                    pins_q <= nfa_pkg::PINS_IDLE;
                    state_q <= nfa_pkg::S_IDLE;
                end
                default: state_q <= nfa_pkg::S_IDLE;
            endcase
        end
    end

    assign CE_N = pins_q.ce_n;
    assign CLE = pins_q.cle;
    assign ALE = pins_q.ale;
    assign WE_N = pins_q.we_n;
    assign RE_N = pins_q.re_n;
    assign IO_O = pins_q.io_o;
    assign IO_OE = pins_q.io_oe;

    // Checker helpers: cycles since last write edge, status output mode
    logic [7:0] since_we_q;
    logic sr_mode_q;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            since_we_q <= 8'h00;
            sr_mode_q <= 1'b0;
        end else begin
            since_we_q <= $rose(pins_q.we_n) ? 8'h00
                : (since_we_q == 8'hFF ? 8'hFF : since_we_q + 8'h01);
            if ($rose(pins_q.we_n) && pins_q.cle)
                sr_mode_q <= pins_q.io_o == nfa_pkg::CMD_STATUS;
        end
    end

    sequence s_feat_cmd;
        $fell(pins_q.we_n) && pins_q.cle
            && (pins_q.io_o == nfa_pkg::CMD_SET || pins_q.io_o == nfa_pkg::CMD_GET);
    endsequence
    // Address strobe must open within a bounded window after the command
    sequence s_addr_follows;
        ##[1:40] (pins_q.ale && !pins_q.we_n);
    endsequence

    chk_feat_idle: assert property (s_feat_cmd |-> $past(rb_s, 1)) // RQ2
        else $error("feature command while target busy");
    chk_feat_addr: assert property (s_feat_cmd |-> s_addr_follows) // RQ4
        else $error("feature address did not follow command");
    chk_adl_wait: assert property ($fell(pins_q.we_n)
            && state_q == nfa_pkg::S_DIN && idx_q == 2'h0
            |-> since_we_q >= nfa_pkg::ADL_CYC) // RQ4
        else $error("first parameter sent before address delay");
    chk_read_mode: assert property ($fell(pins_q.re_n)
            && state_q == nfa_pkg::S_DOUT |-> !sr_mode_q) // RQ11
        else $error("data read while status output enabled");
    chk_dout_ready: assert property ($fell(pins_q.re_n)
            && state_q == nfa_pkg::S_DOUT && !poll_q |-> rb_s) // RQ12
        else $error("parameters read before busy ended");
    chk_reserved_zero: assert property (state_q == nfa_pkg::S_DIN
            && !pins_q.we_n |-> (pins_q.io_o & ~byte_mask(faddr_q, idx_q))
            == 8'h00) // RQ21
        else $error("reserved bit driven nonzero");
    chk_mode_supp: assert property (state_q == nfa_pkg::S_DIN
            && !pins_q.we_n && idx_q == 2'h0 && faddr_q == nfa_pkg::FA_TIMING
            |-> SUPP_MODES[pins_q.io_o[2:0]]) // RQ16
        else $error("unsupported timing mode sent");
    chk_relaxed_strobe: assert property (relaxed_q && $fell(pins_q.we_n)
            |-> (!pins_q.we_n)[*6]) // RQ18
        else $error("write strobe too short in relaxed timing");
    chk_four_bytes: assert property ($rose(state_q == nfa_pkg::S_WB)
            && !get_q |-> $past(idx_q, 1) == 2'h3) // RQ6
        else $error("set features left with fewer than four bytes");

endmodule // nfa_host

/* nfa_target_model.sv */
module nfa_target_model #(
    parameter int FEAT_NS = 600,
    parameter int ITC_NS = 2500
) (
    // Host pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic io_oe,
    input wire logic [7:0] io_o,
    // Target side
    output logic [7:0] io_i,
    output logic rb_n,
    output int faults
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] FMASK [4] = '{8'h07, 8'h03, 8'h03, 8'h0B};
    logic [7:0] feat_q [4];
    logic [7:0] mode_q, fa_q, out_q;
    logic drv_q, stat_q, itc_q;
    int idx_q;
    realtime adl_t;

    // Four slots only; reserved addresses read zero
    function automatic int slot(logic [7:0] a);
        case (a)
            8'h01: return 0;
            8'h80: return 1;
            8'h81: return 2;
            8'h90: return 3;
            default: return -1;
        endcase
    endfunction

    // Busy runs beside the decoder so status polls still land
    task automatic busy(int ns);
        rb_n = 1'b0;
        #(ns);
        rb_n = 1'b1;
    endtask

    // Power-on defaults; a host reset never reaches them
    initial begin
        feat_q = '{default: 8'h00};
        {mode_q, fa_q, out_q} = '0;
        {drv_q, stat_q, itc_q} = '0;
        idx_q = 0;
        adl_t = 0;
        rb_n = 1'b1;
        faults = 0;
    end

    // Released bus shows the inverse of its last byte
    assign io_i = io_oe ? io_o : (drv_q ? out_q : ~out_q);

    // Command, address and parameter capture on the write rise
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            if (!rb_n && io_o != 8'h70) faults++;
            stat_q = (io_o == 8'h70);
            if (io_o == 8'hEF || io_o == 8'hEE) mode_q = io_o;
        end else if (!ce_n && ale) begin
            fa_q = io_o;
            idx_q = 0;
            itc_q = 1'b0;
            adl_t = $realtime;
            if (mode_q == 8'hEE) fork busy(FEAT_NS); join_none
        end else if (!ce_n && mode_q == 8'hEF && idx_q < 4) begin
            if ($realtime - adl_t < 70.0) faults++;
            if (idx_q > 0 && io_o != 8'h00) faults++;
            if (idx_q == 0 && slot(fa_q) >= 0) begin
                if ((io_o & ~FMASK[slot(fa_q)]) != 8'h00) faults++;
                itc_q = (fa_q == 8'h01) && (io_o != feat_q[0]);
                feat_q[slot(fa_q)] = io_o;
            end
            idx_q++;
            if (idx_q == 4) fork busy(itc_q ? ITC_NS : FEAT_NS); join_none
        end
    end

    // Read fall: status byte, or the next parameter byte
    always @(negedge re_n) begin
        if (!ce_n) begin
            if (!rb_n && !stat_q) faults++;
            drv_q = 1'b1;
            if (stat_q) out_q = {1'b1, rb_n, 6'h00};
            else begin
                out_q = 8'h00;
                if (idx_q == 0 && slot(fa_q) >= 0) out_q = feat_q[slot(fa_q)];
                idx_q++;
            end
        end
    end

    // Output hold runs out shortly after the read rise
    always @(posedge re_n) begin
        #5;
        drv_q = 1'b0;
    end
endmodule // nfa_target_model

/* nfa_host_test.sv */
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end

module nfa_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] fa, p1, exp;} nfa_case_t;
    localparam nfa_case_t CASES [9] = '{
        '{8'h01, 8'h03, 8'h03}, '{8'h80, 8'hFF, 8'h03}, '{8'h81, 8'h02, 8'h02},
        '{8'h90, 8'h01, 8'h01}, '{8'h90, 8'h03, 8'h03}, '{8'h90, 8'hFF, 8'h0B},
        '{8'h90, 8'h08, 8'h08}, '{8'h05, 8'hFF, 8'h00}, '{8'h80, 8'h00, 8'h00}};
    logic CLK, RESET_N, WR, RD, RB_N, CE_N, CLE, ALE, WE_N, RE_N, IO_OE;
    logic [3:0] ADDR;
    logic [31:0] WDATA, RDATA, st, d;
    logic [7:0] IO_O, IO_I;
    logic ce_seen;
    int err_total, comparisons, cyc, faults;

    nfa_host nfa_host_i (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CE_N(CE_N),
        .CLE(CLE), .ALE(ALE), .WE_N(WE_N), .RE_N(RE_N), .IO_O(IO_O),
        .IO_OE(IO_OE), .IO_I(IO_I), .RB_N(RB_N));
    nfa_target_model nfa_target_model_i (.ce_n(CE_N), .cle(CLE), .ale(ALE),
        .we_n(WE_N), .re_n(RE_N), .io_oe(IO_OE), .io_o(IO_O), .io_i(IO_I),
        .rb_n(RB_N), .faults(faults));

    // Clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // Watchdog; the full run needs about a tenth of this
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end

    // Any target select at all
    always @(negedge CE_N) ce_seen = 1'b1;

    task automatic summarize();
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask

    // Load address and first byte, start, poll until done
    task automatic feat(input logic [7:0] fa, input logic [7:0] p1,
        input logic [2:0] ctl);
        wr(nfa_pkg::REG_FADDR, {24'h0, fa});
        wr(nfa_pkg::REG_PARAM0, {24'h0, p1});
        wr(nfa_pkg::REG_CTRL, {29'h0, ctl});
        st = '0;
        for (int n = 0; n < 3000 && st[nfa_pkg::ST_DONE] !== 1'b1; n++)
            rd(nfa_pkg::REG_STATUS, st);
    endtask

    task automatic getp(input logic [7:0] fa, input logic poll);
        feat(fa, 8'h00, {poll, 2'b11});
        `CHK(st[2:0], 3'b010)
        rd(nfa_pkg::REG_PARAM0, d);
    endtask

    initial begin
        RESET_N = 1'b0;
        {WR, RD} = 2'b00;
        ADDR = 4'h0;
        WDATA = '0;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(nfa_pkg::REG_STATUS, d);
        `CHK(d, 32'h0)
        rd(4'hF, d);
        `CHK(d, 32'h0)
        // Defaults of every implemented feature, both poll styles
        for (int i = 0; i < 4; i++) begin
            getp(CASES[i].fa, i[0]);
            `CHK(d[7:0], 8'h00)
            for (int j = 3; j < 6; j++) begin
                rd(j[3:0], d);
                `CHK(d[7:0], 8'h00)
            end
        end
        // Write then read back, reserved bits and addresses included
        foreach (CASES[i]) begin
            feat(CASES[i].fa, CASES[i].p1, {i[0], 2'b01});
            `CHK(st[3:0], {i >= 1 && i < 8, 3'b010})
            if (i[0]) `CHK(st[15:8], 8'hC0)
            getp(CASES[i].fa, ~i[0]);
            `CHK(d[7:0], CASES[i].exp)
        end
        // Unsupported timing mode never reaches the pins
        ce_seen = 1'b0;
        feat(8'h01, 8'h04, 3'b001);
        `CHK({ce_seen, st[2]}, 2'b01)
        rd(nfa_pkg::REG_PARAM0, d);
        `CHK(d[15:8], 8'h04)
        getp(8'h01, 1'b0);
        `CHK(d[7:0], 8'h03)
        // Second start and address write while busy are turned away
        wr(nfa_pkg::REG_CTRL, 32'h3);
        feat(8'h90, 8'h00, 3'b011);
        `CHK(st[2:0], 3'b110)
        rd(nfa_pkg::REG_PARAM0, d);
        `CHK(d[7:0], 8'h03)
        // Host reset leaves the target's settings in place
        @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        getp(8'h90, 1'b1);
        `CHK(d[7:0], 8'h08)
        rd(nfa_pkg::REG_CTRL, d);
        `CHK(d, 32'h6)
        `CHK(faults, 0)
        summarize();
    end
endmodule // nfa_host_test
